// ==== rtl/mnac_pkg.sv ====
package mnac_pkg;

  // Address and microword geometry
  localparam int ADDR_W      = 12;
  localparam int UI_W        = 32;
  localparam int BR_LSB      = 0;
  localparam int OP_LSB      = 12;
  localparam int OP_W        = 4;
  localparam int CTL_LSB     = 16;
  localparam int CTL_W       = 16;

  // Machine instruction and mapping table
  localparam int IR_W        = 16;
  localparam int OPC_LSB     = 8;
  localparam int OPC_W       = 8;
  localparam int MAP_DEPTH   = 256;

  // Return and loop stack
  localparam int STK_DEPTH   = 5;
  localparam int STK_PTR_W   = 3;

  // Microprogram memory built from several banks
  localparam int BANK_W      = 2;
  localparam int BANK_AW     = 10;
  localparam int NBANK       = 4;
  localparam int BANK_DEPTH  = 1024;

  // Reset values
  localparam logic [ADDR_W-1:0] RESET_ADDR = 12'h000;
  localparam logic [IR_W-1:0]   RESET_IR   = 16'h0000;
  localparam logic [UI_W-1:0]   RESET_UI   = 32'h00000000;
  // Level read from the direct bus when nothing drives it
  localparam logic [ADDR_W-1:0] DBUS_IDLE  = 12'h000;

  typedef enum logic [1:0] {
    SRC_D  = 2'b00,
    SRC_R  = 2'b01,
    SRC_PC = 2'b10,
    SRC_F  = 2'b11
  } mnac_src_t;

  typedef enum logic [3:0] {
    OP_JZ    = 4'h0,
    OP_CONT  = 4'h1,
    OP_JMAP  = 4'h2,
    OP_JUMP  = 4'h3,
    OP_CJRD  = 4'h4,
    OP_CJSRD = 4'h5,
    OP_CJS   = 4'h6,
    OP_CRTN  = 4'h7,
    OP_PUSH  = 4'h8,
    OP_LOOP  = 4'h9,
    OP_CJP   = 4'hA
  } mnac_op_t;

  function automatic logic [ADDR_W-1:0] addr_inc(
    input logic [ADDR_W-1:0] a
  );
    addr_inc = a + 12'h001;
  endfunction

endpackage

// ==== rtl/mnac_if.sv ====
`timescale 1ns/100ps

interface mnac_stk_if;
  import mnac_pkg::*;
  logic                 push;
  logic                 pop;
  logic                 clear;
  logic [ADDR_W-1:0]    wdata;
  logic [ADDR_W-1:0]    top;
  logic [STK_PTR_W-1:0] depth;
  logic                 full;
  logic                 ovf;

  modport ctl (output push, pop, clear, wdata,
               input  top, depth, full, ovf);
  modport stk (input  push, pop, clear, wdata,
               output top, depth, full, ovf);
endinterface

interface mnac_um_if;
  import mnac_pkg::*;
  logic [ADDR_W-1:0]    addr;
  logic                 we;
  logic [ADDR_W-1:0]    waddr;
  logic [UI_W-1:0]      wdata;
  logic [UI_W-1:0]      pipe;

  modport ctl (output addr, we, waddr, wdata, input pipe);
  modport mem (input  addr, we, waddr, wdata, output pipe);
endinterface

// ==== rtl/mnac_stack.sv ====
`timescale 1ns/100ps

module mnac_stack
  import mnac_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  mnac_stk_if.stk   stk
);

  logic [ADDR_W-1:0]    mem_r [STK_DEPTH];
  logic [STK_PTR_W-1:0] sp_r;
  logic [STK_PTR_W-1:0] sp_nxt;
  logic                 ovf_r;
  logic                 ovf_nxt;

  // Push past five levels is dropped and flagged, never wraps
  always_comb begin
    sp_nxt  = sp_r;
    ovf_nxt = ovf_r;
    if (stk.clear) begin
      sp_nxt = '0;
    end else if (stk.push && !stk.pop) begin
      if (sp_r == STK_PTR_W'(STK_DEPTH)) begin
        ovf_nxt = 1'b1;
      end else begin
        sp_nxt = sp_r + 3'h1;
      end
    end else if (stk.pop && !stk.push && sp_r != '0) begin
      sp_nxt = sp_r - 3'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sp_r  <= '0;
      ovf_r <= 1'b0;
    end else begin
      sp_r  <= sp_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_i && !stk.clear && stk.push && !stk.pop &&
        sp_r != STK_PTR_W'(STK_DEPTH)) begin
      mem_r[sp_r] <= stk.wdata;
    end
  end

  assign stk.top   = (sp_r == '0) ? RESET_ADDR : mem_r[sp_r - 3'h1];
  assign stk.depth = sp_r;
  assign stk.full  = (sp_r == STK_PTR_W'(STK_DEPTH));
  assign stk.ovf   = ovf_r;

  a_stack_bound: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    sp_r <= STK_PTR_W'(STK_DEPTH))
    else $error("stack depth beyond five");

  a_push_grows: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (stk.push && !stk.pop && !stk.clear && sp_r < STK_PTR_W'(STK_DEPTH))
    |=> sp_r == $past(sp_r) + 3'h1 && stk.top == $past(stk.wdata))
    else $error("push did not store return address");

endmodule

// ==== rtl/mnac_upmem.sv ====
`timescale 1ns/100ps

module mnac_upmem
  import mnac_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  mnac_um_if.mem    um
);

  logic [UI_W-1:0]   mem [NBANK][BANK_DEPTH];
  logic [BANK_W-1:0] bank_sel;
  logic [UI_W-1:0]   word;
  logic [UI_W-1:0]   pipe_r;
  logic [UI_W-1:0]   pipe_nxt;

  // Bank decode runs beside the array read, no extra cycle
  // parallel bank decode
  always_comb begin
    bank_sel = um.addr[ADDR_W-1 -: BANK_W];
    word     = mem[bank_sel][um.addr[BANK_AW-1:0]];
    pipe_nxt = reset_i ? RESET_UI : word;
  end

  always_ff @(posedge ref_clk_i) begin
    pipe_r <= pipe_nxt;
  end

  always_ff @(posedge ref_clk_i) begin
    if (um.we) begin
      mem[um.waddr[ADDR_W-1 -: BANK_W]][um.waddr[BANK_AW-1:0]] <= um.wdata;
    end
  end

  assign um.pipe = pipe_r;

  a_fetch_one: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !reset_i |=> pipe_r == $past(word))
    else $error("pipeline missed fetched word");

endmodule

// ==== rtl/mnac_ccu.sv ====
// Contract
// - Next address comes from direct bus, branch register, counter or stack.
// - Mapping table and branch field share the direct bus, each gated.
// - First microstep of an instruction takes the mapped start address.
// - A jump takes the branch field of the current microword.
// - Branch register loads the direct bus every cycle.
// - Two-way branch picks current branch field or previous direct bus value.
// - Sequential steps take the microprogram counter.
// - Sequential steps keep the branch field on the direct bus.
// - Stack holds five 12-bit return or loop addresses.
// - Instruction register loads from the data bus and feeds the map.
// - Pipeline register holds the executing microword.
// - Bank decode of deep microprogram memory adds no cycle.
`timescale 1ns/100ps

module mnac_ccu
  import mnac_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  input  wire logic [IR_W-1:0]   data_bus_i,
  input  wire logic              ir_load_i,
  input  wire logic              cond_i,
  input  wire logic              ucode_we_i,
  input  wire logic [ADDR_W-1:0] ucode_waddr_i,
  input  wire logic [UI_W-1:0]   ucode_wdata_i,
  input  wire logic              map_we_i,
  input  wire logic [OPC_W-1:0]  map_waddr_i,
  input  wire logic [ADDR_W-1:0] map_wdata_i,
  output logic      [ADDR_W-1:0] uaddr_o,
  output logic      [CTL_W-1:0]  micro_ctl_o,
  output logic                   map_en_o,
  output logic                   br_en_o,
  output logic      [STK_PTR_W-1:0] stack_depth_o,
  output logic                   stack_ovf_o
);

  mnac_stk_if stk_if ();
  mnac_um_if  um_if ();

  logic [ADDR_W-1:0] map_mem [MAP_DEPTH];
  logic [ADDR_W-1:0] map_val;

  logic [IR_W-1:0]   ir_r;
  logic [IR_W-1:0]   ir_nxt;
  logic [ADDR_W-1:0] breg_r;
  logic [ADDR_W-1:0] breg_nxt;
  logic [ADDR_W-1:0] pc_r;
  logic [ADDR_W-1:0] pc_nxt;
  logic [ADDR_W-1:0] uaddr_r;

  logic [UI_W-1:0]   pipe;
  logic [ADDR_W-1:0] br_fld;
  mnac_op_t          op;
  mnac_src_t         src;
  logic              map_en;
  logic              br_en;
  logic              push;
  logic              pop;
  logic              clr;
  logic [ADDR_W-1:0] dbus;
  logic [ADDR_W-1:0] next_addr;

  mnac_stack u_stack (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .stk       (stk_if.stk)
  );

  mnac_upmem u_upmem (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .um        (um_if.mem)
  );

  // Instruction register and its map lookup
  // instruction load
  always_comb begin
    ir_nxt = ir_r;
    if (reset_i) begin
      ir_nxt = RESET_IR;
    end else if (ir_load_i) begin
      ir_nxt = data_bus_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    ir_r <= ir_nxt;
  end

  // Table has no reset; software loads it before the first mapped step
  always_ff @(posedge ref_clk_i) begin
    if (map_we_i) begin
      map_mem[map_waddr_i] <= map_wdata_i;
    end
  end

  assign map_val = map_mem[ir_r[OPC_LSB +: OPC_W]];

  // Decode of the executing microword
  assign pipe   = um_if.pipe;
  assign br_fld = pipe[BR_LSB +: ADDR_W];
  assign op     = mnac_op_t'(pipe[OP_LSB +: OP_W]);

  always_comb begin
    src    = SRC_PC;
    map_en = 1'b0;
    br_en  = 1'b1;
    push   = 1'b0;
    pop    = 1'b0;
    clr    = 1'b0;
    case (op)
      OP_JZ: begin
        // Idle bus reads zero, so this restarts at address zero
        src   = SRC_D;
        br_en = 1'b0;
        clr   = 1'b1;
      end
      OP_JMAP: begin
        src    = SRC_D;
        map_en = 1'b1;
        br_en  = 1'b0;
      end
      OP_JUMP: begin
        src = SRC_D;
      end
      OP_CJP: begin
        if (cond_i) begin
          src = SRC_D;
        end
      end
      OP_CJRD: begin
        src = cond_i ? SRC_D : SRC_R;
      end
      OP_CJSRD: begin
        src  = cond_i ? SRC_D : SRC_R;
        push = 1'b1;
      end
      OP_CJS: begin
        if (cond_i) begin
          src  = SRC_D;
          push = 1'b1;
        end
      end
      OP_CRTN: begin
        if (cond_i) begin
          src = SRC_F;
          pop = 1'b1;
        end
      end
      OP_PUSH: begin
        push = 1'b1;
      end
      OP_LOOP: begin
        if (cond_i) begin
          pop = 1'b1;
        end else begin
          src = SRC_F;
        end
      end
      default: begin
        src = SRC_PC;
      end
    endcase
  end

  // Shared direct bus; map wins by its place first in the priority chain, and the decode never sets both
  // gated bus drivers
  always_comb begin
    if (map_en) begin
      dbus = map_val;
    end else if (br_en) begin
      dbus = br_fld;
    end else begin
      dbus = DBUS_IDLE;
    end
  end

  always_comb begin
    case (src)
      SRC_D:   next_addr = dbus;
      SRC_R:   next_addr = breg_r;
      SRC_PC:  next_addr = pc_r;
      default: next_addr = stk_if.top;
    endcase
  end

  // Return address is the step after the current one
  assign stk_if.push  = push;
  assign stk_if.pop   = pop;
  assign stk_if.clear = clr;
  assign stk_if.wdata = pc_r;

  assign um_if.addr  = next_addr;
  assign um_if.we    = ucode_we_i;
  assign um_if.waddr = ucode_waddr_i;
  assign um_if.wdata = ucode_wdata_i;

  always_comb begin
    breg_nxt = reset_i ? RESET_ADDR : dbus;
    pc_nxt   = reset_i ? addr_inc(RESET_ADDR) : addr_inc(next_addr);
  end

  always_ff @(posedge ref_clk_i) begin
    breg_r  <= breg_nxt;
    pc_r    <= pc_nxt;
    uaddr_r <= reset_i ? RESET_ADDR : next_addr;
  end

  assign uaddr_o       = uaddr_r;
  assign micro_ctl_o   = pipe[CTL_LSB +: CTL_W];
  assign map_en_o      = map_en;
  assign br_en_o       = br_en;
  assign stack_depth_o = stk_if.depth;
  assign stack_ovf_o   = stk_if.ovf;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  a_bus_exclusive: assert property (!(map_en && br_en))
    else $error("map and branch field both on bus");

  a_jmap_start: assert property (op == OP_JMAP |->
    map_en && !br_en && next_addr == map_val)
    else $error("mapped step did not take map output");

  a_jump_target: assert property (op == OP_JUMP |->
    br_en && next_addr == br_fld)
    else $error("jump did not take branch field");

  a_breg_load: assert property (1'b1 |=> breg_r == $past(dbus))
    else $error("branch register missed bus value");

  a_two_way: assert property (op == OP_CJRD |->
    next_addr == (cond_i ? br_fld : $past(dbus)))
    else $error("two-way branch picked wrong source");

  a_seq_count: assert property (op == OP_CONT |=>
    uaddr_r == $past(pc_r) && pc_r == $past(pc_r) + 12'h001)
    else $error("sequential step skipped an address");

  a_seq_field: assert property (op == OP_CONT |-> br_en && dbus == br_fld)
    else $error("branch field off bus in sequence");

  a_ir_load: assert property (ir_load_i |=> ir_r == $past(data_bus_i))
    else $error("instruction register missed load");

  a_call_return: assert property (op == OP_CJS && cond_i && !stk_if.full
    |=> stk_if.top == $past(pc_r))
    else $error("call lost return address");

  c_mapped: cover property (ir_load_i ##1 op == OP_JMAP);
  c_two_way: cover property (op == OP_CJSRD && !cond_i);
  c_loop: cover property (op == OP_LOOP && !cond_i ##1 op == OP_LOOP);
  c_deep: cover property (stk_if.full);

endmodule

// ==== verif/mnac_uprog_model.sv ====
`timescale 1ns/100ps

module mnac_uprog_model
  import mnac_pkg::*;
(
  input  wire logic              ref_clk_i,
  output logic                   ucode_we_o,
  output logic      [ADDR_W-1:0] ucode_waddr_o,
  output logic      [UI_W-1:0]   ucode_wdata_o,
  output logic                   map_we_o,
  output logic      [OPC_W-1:0]  map_waddr_o,
  output logic      [ADDR_W-1:0] map_wdata_o
);
  // Writes follow first use, so loading may run past reset
  localparam int N = 13;
  logic [ADDR_W-1:0] a_tab [N];
  mnac_op_t          o_tab [N];
  logic [ADDR_W-1:0] b_tab [N];
  int                idx = 0;

  // nesting within five
  // Only the overflow loop at 0x010 goes deeper, on command
  initial begin
    a_tab = '{12'h000, 12'h001, 12'h100, 12'h101, 12'h200, 12'h280,
              12'h201, 12'h010, 12'h011, 12'hC00, 12'h800, 12'h801,
              12'h802};
    o_tab = '{OP_CONT, OP_JMAP, OP_CONT, OP_CJRD, OP_CJS, OP_CRTN,
              OP_JUMP, OP_CJS, OP_JZ, OP_CJRD, OP_PUSH, OP_LOOP, OP_JZ};
    b_tab = '{12'h055, 12'h000, 12'h200, 12'h300, 12'h280, 12'h000,
              12'h010, 12'h010, 12'h000, 12'h800, 12'h000, 12'h000,
              12'h000};
    ucode_we_o    = 1'h0;
    ucode_waddr_o = 12'h000;
    ucode_wdata_o = 32'h00000000;
    map_we_o      = 1'h0;
    map_waddr_o   = 8'h00;
    map_wdata_o   = 12'h000;
  end

  always @(posedge ref_clk_i) begin
    ucode_we_o <= (idx < N);
    if (idx < N) begin
      ucode_waddr_o <= a_tab[idx];
      ucode_wdata_o <= {4'hA, a_tab[idx], o_tab[idx], b_tab[idx]};
    end
    map_we_o    <= (idx < 2);
    map_waddr_o <= (idx == 0) ? 8'h34 : 8'h7F;
    map_wdata_o <= (idx == 0) ? 12'h100 : 12'hC00;
    idx         <= idx + 1;
  end
endmodule

// ==== verif/mnac_ccu_tb.sv ====
`timescale 1ns/100ps

module mnac_ccu_tb;
  import mnac_pkg::*;
  logic                 ref_clk_i;
  logic                 reset_i;
  logic [IR_W-1:0]      data_bus_i;
  logic                 ir_load_i;
  logic                 cond_i;
  logic                 u_we;
  logic [ADDR_W-1:0]    u_waddr;
  logic [UI_W-1:0]      u_wdata;
  logic                 m_we;
  logic [OPC_W-1:0]     m_waddr;
  logic [ADDR_W-1:0]    m_wdata;
  logic [ADDR_W-1:0]    uaddr_o;
  logic [CTL_W-1:0]     micro_ctl_o;
  logic                 map_en_o;
  logic                 br_en_o;
  logic [STK_PTR_W-1:0] stack_depth_o;
  logic                 stack_ovf_o;
  int                   checks = 0;
  int                   mismatches = 0;

  mnac_ccu i_mnac_ccu (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .data_bus_i(data_bus_i),
    .ir_load_i(ir_load_i), .cond_i(cond_i), .ucode_we_i(u_we),
    .ucode_waddr_i(u_waddr), .ucode_wdata_i(u_wdata), .map_we_i(m_we),
    .map_waddr_i(m_waddr), .map_wdata_i(m_wdata), .uaddr_o(uaddr_o),
    .micro_ctl_o(micro_ctl_o), .map_en_o(map_en_o), .br_en_o(br_en_o),
    .stack_depth_o(stack_depth_o), .stack_ovf_o(stack_ovf_o));

  mnac_uprog_model i_mnac_uprog_model (
    .ref_clk_i(ref_clk_i), .ucode_we_o(u_we), .ucode_waddr_o(u_waddr),
    .ucode_wdata_o(u_wdata), .map_we_o(m_we), .map_waddr_o(m_waddr),
    .map_wdata_o(m_wdata));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // En 2'h3 skips the enable check where the choice is open
  task automatic step(input logic [11:0] a, input logic c,
                      input logic [1:0] en, input logic [2:0] d,
                      input logic [15:0] ld);
    @(posedge ref_clk_i);
    cond_i     <= c;
    ir_load_i  <= (ld != 16'h0000);
    data_bus_i <= ld;
    #1;
    check(uaddr_o, a);
    check(micro_ctl_o, {4'hA, a});
    check(stack_depth_o, d);
    check(map_en_o & br_en_o, 1'h0);
    if (en != 2'h3)
      check({map_en_o, br_en_o}, en);
  endtask

  task automatic t_map_seq();
    step(12'h000, 1'h0, 2'h1, 3'h0, 16'h0000);
    step(12'h001, 1'h0, 2'h2, 3'h0, 16'h0000);
    step(12'h100, 1'h0, 2'h1, 3'h0, 16'h0000);
    step(12'h101, 1'h0, 2'h1, 3'h0, 16'h0000);
    $display("map and sequence test done");
  endtask

  task automatic t_call_jump();
    step(12'h200, 1'h1, 2'h3, 3'h0, 16'h0000);
    step(12'h280, 1'h1, 2'h3, 3'h1, 16'h0000);
    step(12'h201, 1'h0, 2'h1, 3'h0, 16'h0000);
    step(12'h010, 1'h1, 2'h3, 3'h0, 16'h0000);
    $display("call and jump test done");
  endtask

  task automatic t_overflow();
    for (int i = 1; i <= 5; i++)
      step(12'h010, 1'h1, 2'h3, i[2:0], 16'h0000);
    check(stack_ovf_o, 1'h0);
    step(12'h010, 1'h0, 2'h3, 3'h5, 16'h0000);
    check(stack_ovf_o, 1'h1);
    step(12'h011, 1'h0, 2'h3, 3'h5, 16'h7F00);
    $display("stack overflow test done");
  endtask

  task automatic t_bank();
    step(12'h000, 1'h0, 2'h1, 3'h0, 16'h0000);
    step(12'h001, 1'h0, 2'h2, 3'h0, 16'h0000);
    step(12'hC00, 1'h1, 2'h1, 3'h0, 16'h0000);
    step(12'h800, 1'h0, 2'h3, 3'h0, 16'h0000);
    $display("bank and two-way test done");
  endtask

  task automatic t_loop();
    step(12'h801, 1'h0, 2'h3, 3'h1, 16'h0000);
    step(12'h801, 1'h1, 2'h3, 3'h1, 16'h0000);
    step(12'h802, 1'h0, 2'h3, 3'h0, 16'h0000);
    step(12'h000, 1'h0, 2'h1, 3'h0, 16'h0000);
    $display("loop test done");
  endtask

  initial begin
    ref_clk_i = 1'h0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // Whole run is under fifty cycles
  initial begin
    #2000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    reset_i    = 1'h1;
    cond_i     = 1'h0;
    ir_load_i  = 1'h0;
    data_bus_i = 16'h0000;
    repeat (10) @(posedge ref_clk_i);
    reset_i    <= 1'h0;
    ir_load_i  <= 1'h1;
    data_bus_i <= 16'h3400;
    t_map_seq();
    t_call_jump();
    t_overflow();
    t_bank();
    t_loop();
    tally_and_finish();
  end
endmodule
